// [design/spg_pkg.sv]
// How it works
// - Pulse width is 16 bits in 10 ns units, loaded from config, read-only.
// - Zero width selects acknowledge mode: output held until its status is read by the network or acknowledged by the host.
// - Activation state bits 0 and 1 show first pulse still pending per output.
// - Activation state bit 2 records start time outside near future at activation.
// - Per-output status shows pending in bit 0, bits 7:1 read zero.
// - Write-ack off: host read of first status clears first event request.
// - Write-ack on: host write to a status register clears its event request.
// - Second status host access clears the second event request the same way.
// - Start time write sets cyclic start; read returns next first pulse time.
// - Start time writes are ignored while the unit is active.
// - Auto-activation: lone lower-half write in one frame is extended to 64 bits.
// - Read-only next second pulse time, reset to zero.
// - 32-bit first output period in ns, reset to zero.
// - Zero period gives single shot: one first pulse, then stop.
// - 32-bit delay in ns from first pulse to following second pulse.
// - Start, period and delay writes honoured only from the owning side.
// - Ownership bit zero selects network side, one selects host side.
// - Activation register holds unit enable, output enables and auto-activate.
// - Plausibility check fires at once if start lies outside the near future.
package spg_pkg;
   localparam logic [11:0] ADDR_CTRL = 12'h980;
   localparam logic [11:0] ADDR_ACT = 12'h981;
   localparam logic [11:0] ADDR_WIDTH_LO = 12'h982;
   localparam logic [11:0] ADDR_WIDTH_HI = 12'h983;
   localparam logic [11:0] ADDR_ACT_STATE = 12'h984;
   localparam logic [11:0] ADDR_FIRST_STATE = 12'h98e;
   localparam logic [11:0] ADDR_SECOND_STATE = 12'h98f;
   localparam logic [11:0] ADDR_START = 12'h990;
   localparam logic [11:0] ADDR_NEXT_SECOND = 12'h998;
   localparam logic [11:0] ADDR_PERIOD = 12'h9a0;
   localparam logic [11:0] ADDR_DELAY = 12'h9a4;
   // Activation register fields
   localparam int ACT_UNIT = 0;
   localparam int ACT_FIRST = 1;
   localparam int ACT_SECOND = 2;
   localparam int ACT_AUTO = 3;
   localparam int ACT_EXTEND = 4;
   localparam int ACT_PLAUS = 5;
   localparam int ACT_NEAR = 6;
   localparam int ACT_DEBUG = 7;
   localparam int CTRL_OWNER = 0;
   localparam int STATE_OUT_NEAR = 2;
   localparam logic [7:0] ACT_RESET = 8'h00;
   localparam logic [15:0] WIDTH_RESET = 16'h0000;
   localparam logic [63:0] TIME_RESET = 64'h0;
   localparam logic [31:0] PERIOD_RESET = 32'h0;
   // Pulse width unit and clock period, both in ns
   localparam int WIDTH_UNIT_NS = 10;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CYCLES_PER_UNIT =
      (WIDTH_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {MODE_OFF, MODE_RUN, MODE_DONE} spg_mode_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
      logic [7:0] wdata;
   } spg_bus_req_type;
endpackage : spg_pkg

// [design/spg_pulse_shaper.sv]
module spg_pulse_shaper
   import spg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic trigger,
   input wire logic [15:0] width,
   input wire logic ack,
   output logic pulseOut
);
   typedef struct packed {
      logic level;
      logic [31:0] remain;
   } spg_shaper_type;

   spg_shaper_type s_reg;
   spg_shaper_type s_next;

   always_comb
   begin
      s_next = s_reg;
      if (width == 16'h0000)
      begin
         s_next.remain = 32'h0;
         // Trigger wins over an ack in the same cycle
         if (ack)
            s_next.level = 1'b0;
         if (trigger)
            s_next.level = 1'b1;
      end
      else if (trigger)
      begin
         s_next.level = 1'b1;
         s_next.remain = 32'(width * CYCLES_PER_UNIT) - 32'h1;
      end
      else if (s_reg.remain != 32'h0)
         s_next.remain = s_reg.remain - 32'h1;
      else
         s_next.level = 1'b0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign pulseOut = s_reg.level;
endmodule : spg_pulse_shaper

// [design/spg_sync_pulse_generator.sv]
module spg_sync_pulse_generator
   import spg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [63:0] sysTime,
   input wire spg_bus_req_type netReq,
   output logic [7:0] netRdata,
   input wire spg_bus_req_type hostReq,
   output logic [7:0] hostRdata,
   input wire logic hostWriteAck,
   input wire logic frameEnd,
   input wire logic cfgWidthValid,
   input wire logic [15:0] cfgWidth,
   output logic firstPulseOut,
   output logic secondPulseOut,
   output logic appEventFirst,
   output logic appEventSecond
);
   typedef struct packed {
      logic owner;
      logic [6:0] act;
      logic [15:0] width;
      logic outNear;
      logic pendFirst;
      logic pendSecond;
      logic [63:0] nextFirst;
      logic [63:0] nextSecond;
      logic secondArmed;
      logic [31:0] period;
      logic [31:0] delay;
      logic lowWritten;
      logic highWritten;
      spg_mode_type mode;
      logic evFirst;
      logic evSecond;
      logic [7:0] netRdata;
      logic [7:0] hostRdata;
   } spg_state_type;

   spg_state_type s_reg;
   spg_state_type s_next;
   logic firstFire;
   logic secondFire;
   logic ackFirst;
   logic ackSecond;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic isStart(input logic [11:0] a);
      return a[11:3] == ADDR_START[11:3];
   endfunction : isStart

   function automatic logic isNextSecond(input logic [11:0] a);
      return a[11:3] == ADDR_NEXT_SECOND[11:3];
   endfunction : isNextSecond

   function automatic logic isPeriod(input logic [11:0] a);
      return a[11:2] == ADDR_PERIOD[11:2];
   endfunction : isPeriod

   function automatic logic isDelay(input logic [11:0] a);
      return a[11:2] == ADDR_DELAY[11:2];
   endfunction : isDelay

   function automatic logic [7:0] readByte(input spg_state_type st,
                                           input logic [11:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a == ADDR_CTRL)
         d = {7'h00, st.owner};
      else if (a == ADDR_ACT)
         d = {1'b0, st.act}; // Debug bit always reads zero
      else if (a == ADDR_WIDTH_LO)
         d = st.width[7:0];
      else if (a == ADDR_WIDTH_HI)
         d = st.width[15:8];
      else if (a == ADDR_ACT_STATE)
         d = {5'h00, st.outNear, st.pendSecond, st.pendFirst};
      else if (a == ADDR_FIRST_STATE)
         d = {7'h00, st.pendFirst};
      else if (a == ADDR_SECOND_STATE)
         d = {7'h00, st.pendSecond};
      else if (isStart(a))
         d = st.nextFirst[8 * a[2:0] +: 8];
      else if (isNextSecond(a))
         d = st.nextSecond[8 * a[2:0] +: 8];
      else if (isPeriod(a))
         d = st.period[8 * a[1:0] +: 8];
      else if (isDelay(a))
         d = st.delay[8 * a[1:0] +: 8];
      return d;
   endfunction : readByte

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb
   begin
      logic netWr;
      logic netRd;
      logic hostWr;
      logic hostRd;
      logic ownWr;
      logic [11:0] ownAddr;
      logic [7:0] ownData;
      logic activate;
      logic deactivate;
      logic debugPing;
      logic clrFirst;
      logic clrSecond;
      logic [63:0] diff;
      logic outside;
      netWr = 1'b0;
      netRd = 1'b0;
      hostWr = 1'b0;
      hostRd = 1'b0;
      ownWr = 1'b0;
      ownAddr = 12'h000;
      ownData = 8'h00;
      activate = 1'b0;
      deactivate = 1'b0;
      debugPing = 1'b0;
      clrFirst = 1'b0;
      clrSecond = 1'b0;
      diff = 64'h0;
      outside = 1'b0;
      firstFire = 1'b0;
      secondFire = 1'b0;
      s_next = s_reg;

      netWr = netReq.valid && netReq.write;
      netRd = netReq.valid && !netReq.write;
      hostWr = hostReq.valid && hostReq.write;
      hostRd = hostReq.valid && !hostReq.write;
      s_next.netRdata = readByte(s_reg, netReq.addr);
      s_next.hostRdata = readByte(s_reg, hostReq.addr);

      if (cfgWidthValid)
         s_next.width = cfgWidth;

      // Only the network side may hand over ownership
      if (netWr && netReq.addr == ADDR_CTRL)
         s_next.owner = netReq.wdata[CTRL_OWNER];

      // Gated writes come only from the owning side
      ownWr = s_reg.owner ? hostWr : netWr;
      ownAddr = s_reg.owner ? hostReq.addr : netReq.addr;
      ownData = s_reg.owner ? hostReq.wdata : netReq.wdata;

      if (ownWr)
      begin
         if (ownAddr == ADDR_ACT)
         begin
            s_next.act = ownData[6:0];
            s_next.act[ACT_UNIT] = s_reg.act[ACT_UNIT];
            activate = ownData[ACT_UNIT] && !s_reg.act[ACT_UNIT];
            deactivate = !ownData[ACT_UNIT] && s_reg.act[ACT_UNIT];
            debugPing = ownData[ACT_DEBUG];
         end
         else if (isStart(ownAddr) && !s_reg.act[ACT_UNIT])
         begin
            s_next.nextFirst[8 * ownAddr[2:0] +: 8] = ownData;
            if (ownAddr[2])
               s_next.highWritten = 1'b1;
            else
               s_next.lowWritten = 1'b1;
         end
         else if (isPeriod(ownAddr))
            s_next.period[8 * ownAddr[1:0] +: 8] = ownData;
         else if (isDelay(ownAddr))
            s_next.delay[8 * ownAddr[1:0] +: 8] = ownData;
      end

      // Frame end closes a start time write burst
      if (frameEnd && (s_reg.lowWritten || s_reg.highWritten))
      begin
         s_next.lowWritten = 1'b0;
         s_next.highWritten = 1'b0;
         if ((s_reg.act[ACT_AUTO] || s_reg.act[ACT_EXTEND])
             && s_reg.lowWritten && !s_reg.highWritten)
            // Lower half below now means the next upper epoch
            s_next.nextFirst[63:32] = sysTime[63:32]
               + {31'h0, s_next.nextFirst[31:0] < sysTime[31:0]};
         if (s_reg.act[ACT_AUTO] && !s_reg.act[ACT_UNIT])
            activate = 1'b1;
      end

      if (activate)
      begin
         diff = s_next.nextFirst - sysTime;
         // Past start times wrap to huge differences and count as outside
         outside = s_next.act[ACT_NEAR] ? (|diff[63:31]) : diff[63];
         s_next.outNear = outside;
         s_next.pendFirst = s_next.act[ACT_FIRST];
         s_next.pendSecond = s_next.act[ACT_SECOND];
         s_next.act[ACT_UNIT] = 1'b1;
         s_next.secondArmed = 1'b0;
         s_next.mode = MODE_RUN;
         if (s_next.act[ACT_PLAUS] && outside)
            s_next.nextFirst = sysTime;
      end
      else if (deactivate)
      begin
         s_next.act[ACT_UNIT] = 1'b0;
         s_next.mode = MODE_OFF;
         s_next.pendFirst = 1'b0;
         s_next.pendSecond = 1'b0;
         s_next.secondArmed = 1'b0;
      end
      else
      begin
         case (s_reg.mode)
            MODE_RUN:
            begin
               if (s_reg.secondArmed)
               begin
                  diff = sysTime - s_reg.nextSecond;
                  if (!diff[63])
                  begin
                     secondFire = s_reg.act[ACT_SECOND];
                     s_next.pendSecond = 1'b0;
                     s_next.secondArmed = 1'b0;
                  end
               end
               diff = sysTime - s_reg.nextFirst;
               if (!diff[63])
               begin
                  firstFire = s_reg.act[ACT_FIRST];
                  s_next.pendFirst = 1'b0;
                  s_next.nextSecond = s_reg.nextFirst
                     + {32'h0, s_reg.delay};
                  s_next.secondArmed = 1'b1;
                  if (s_reg.period == 32'h0)
                     s_next.mode = MODE_DONE;
                  else
                     s_next.nextFirst = s_reg.nextFirst
                        + {32'h0, s_reg.period};
               end
            end
            MODE_DONE:
            begin
               // Single shot still owes its second pulse
               if (s_reg.secondArmed)
               begin
                  diff = sysTime - s_reg.nextSecond;
                  if (!diff[63])
                  begin
                     secondFire = s_reg.act[ACT_SECOND];
                     s_next.pendSecond = 1'b0;
                     s_next.secondArmed = 1'b0;
                  end
               end
            end
            default:
            begin
               s_next.secondArmed = 1'b0;
            end
         endcase
      end

      if (debugPing)
      begin
         firstFire = firstFire || s_next.act[ACT_FIRST];
         secondFire = secondFire || s_next.act[ACT_SECOND];
      end

      // Host acknowledge by read or by write per configuration
      clrFirst = hostWriteAck
         ? (hostWr && hostReq.addr == ADDR_FIRST_STATE)
         : (hostRd && hostReq.addr == ADDR_FIRST_STATE);
      clrSecond = hostWriteAck
         ? (hostWr && hostReq.addr == ADDR_SECOND_STATE)
         : (hostRd && hostReq.addr == ADDR_SECOND_STATE);
      // A new pulse beats a clear in the same cycle
      s_next.evFirst = (s_reg.evFirst && !clrFirst) || firstFire;
      s_next.evSecond = (s_reg.evSecond && !clrSecond) || secondFire;
      ackFirst = clrFirst || (netRd && netReq.addr == ADDR_FIRST_STATE);
      ackSecond = clrSecond || (netRd && netReq.addr == ADDR_SECOND_STATE);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.act <= ACT_RESET[6:0];
         s_reg.width <= WIDTH_RESET;
         s_reg.nextFirst <= TIME_RESET;
         s_reg.nextSecond <= TIME_RESET;
         s_reg.period <= PERIOD_RESET;
         s_reg.delay <= PERIOD_RESET;
         s_reg.mode <= MODE_OFF;
      end
      else
         s_reg <= s_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output shaping

   spg_pulse_shaper firstShaper (
      .clk(clk),
      .rst(rst),
      .trigger(firstFire),
      .width(s_reg.width),
      .ack(ackFirst),
      .pulseOut(firstPulseOut)
   );

   spg_pulse_shaper secondShaper (
      .clk(clk),
      .rst(rst),
      .trigger(secondFire),
      .width(s_reg.width),
      .ack(ackSecond),
      .pulseOut(secondPulseOut)
   );

   assign netRdata = s_reg.netRdata;
   assign hostRdata = s_reg.hostRdata;
   assign appEventFirst = s_reg.evFirst;
   assign appEventSecond = s_reg.evSecond;
endmodule : spg_sync_pulse_generator

// [verif/spg_bus_model.sv]
module spg_bus_model
   import spg_pkg::*;
(
   input wire logic clk,
   output spg_bus_req_type req,
   output logic readSeen
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   always @(posedge clk)
   begin
      readSeen <= req.valid && !req.write;
   end
   // Idle lines show inverted leftovers, never a stale request
   task automatic access(input logic w, input logic [11:0] a,
                         input logic [7:0] d);
      @(posedge clk);
      req <= '{1'b1, w, a, d};
      @(posedge clk);
      req <= '{1'b0, ~w, ~a, ~d};
   endtask : access
endmodule : spg_bus_model

// [verif/spg_monitor.sv]
module spg_monitor
   import spg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire spg_bus_req_type netReq,
   input wire logic [7:0] netRdata,
   input wire spg_bus_req_type hostReq,
   input wire logic [7:0] hostRdata,
   input wire logic hostWriteAck,
   input wire logic firstPulseOut,
   input wire logic secondPulseOut,
   input wire logic appEventFirst,
   input wire logic appEventSecond
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking mcb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic netRd;
   logic hostRd;
   logic hostWr;
   logic hostFirst;
   assign netRd = netReq.valid && !netReq.write;
   assign hostRd = hostReq.valid && !hostReq.write;
   assign hostWr = hostReq.valid && hostReq.write;
   assign hostFirst = hostReq.valid && hostReq.addr == ADDR_FIRST_STATE;
   ////////////////////////////////////////////////////////////////////
   // A fresh fire may set the event again, hence the pulse escape
   property p_first_bits;
      netRd && netReq.addr == ADDR_FIRST_STATE |=> netRdata[7:1] == 7'h00;
   endproperty
   a_first_bits: assert property (p_first_bits)
      else $error("first status reserved bits not zero");
   property p_act_bits;
      netRd && netReq.addr == ADDR_ACT_STATE |=> netRdata[7:3] == 5'h00;
   endproperty
   a_act_bits: assert property (p_act_bits)
      else $error("activation state reserved bits not zero");
   property p_rd_clear;
      hostRd && hostFirst && !hostWriteAck |=> !appEventFirst || firstPulseOut;
   endproperty
   a_rd_clear: assert property (p_rd_clear)
      else $error("host read left first event set");
   property p_wr_keep;
      hostWr && hostFirst && !hostWriteAck && appEventFirst |=> appEventFirst;
   endproperty
   a_wr_keep: assert property (p_wr_keep)
      else $error("host write cleared first event without ack mode");
   property p_wr_clear;
      hostWr && hostFirst && hostWriteAck |=> !appEventFirst || firstPulseOut;
   endproperty
   a_wr_clear: assert property (p_wr_clear)
      else $error("host write ack left first event set");
   property p_second_clear;
      hostRd && hostReq.addr == ADDR_SECOND_STATE && !hostWriteAck
         |=> !appEventSecond || secondPulseOut;
   endproperty
   a_second_clear: assert property (p_second_clear)
      else $error("host read left second event set");
   property p_ev1; $rose(appEventFirst) |-> firstPulseOut; endproperty
   a_ev1: assert property (p_ev1)
      else $error("first event without first pulse");
   property p_ev2; $rose(appEventSecond) |-> secondPulseOut; endproperty
   a_ev2: assert property (p_ev2)
      else $error("second event without second pulse");
   property p_cause; $fell(appEventFirst) |-> $past(hostFirst); endproperty
   a_cause: assert property (p_cause)
      else $error("first event cleared without host access");
   c_first: cover property ($rose(firstPulseOut));
   c_second: cover property ($rose(secondPulseOut));
   c_clear: cover property ($fell(appEventFirst));
endmodule : spg_monitor

bind spg_sync_pulse_generator spg_monitor u_monitor (.clk(clk), .rst(rst),
   .netReq(netReq), .netRdata(netRdata), .hostReq(hostReq),
   .hostRdata(hostRdata), .hostWriteAck(hostWriteAck),
   .firstPulseOut(firstPulseOut), .secondPulseOut(secondPulseOut),
   .appEventFirst(appEventFirst), .appEventSecond(appEventSecond));

// [verif/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import spg_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hostWriteAck = 1'b0;
   logic frameEnd = 1'b0;
   logic cfgWidthValid = 1'b0;
   logic [15:0] cfgWidth = 16'h0000;
   logic [63:0] sysTime = 64'h0000_0005_0000_0000;
   logic [63:0] st, r, t1, t2, t3;
   spg_bus_req_type netReq, hostReq;
   logic [7:0] netRdata, hostRdata;
   logic firstPulseOut, secondPulseOut, appEventFirst, appEventSecond;
   logic netSeen, hostSeen;
   logic [7:0] netQ[$];
   logic [7:0] hostQ[$];
   int failCount = 0;
   int samplesChecked = 0;
   int seed = 46222;

   spg_bus_model netM (.clk(clk), .req(netReq), .readSeen(netSeen));
   spg_bus_model hostM (.clk(clk), .req(hostReq), .readSeen(hostSeen));
   spg_sync_pulse_generator dut (.clk(clk), .rst(rst), .sysTime(sysTime),
      .netReq(netReq), .netRdata(netRdata), .hostReq(hostReq),
      .hostRdata(hostRdata), .hostWriteAck(hostWriteAck),
      .frameEnd(frameEnd), .cfgWidthValid(cfgWidthValid),
      .cfgWidth(cfgWidth), .firstPulseOut(firstPulseOut),
      .secondPulseOut(secondPulseOut), .appEventFirst(appEventFirst),
      .appEventSecond(appEventSecond));

   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      sysTime <= sysTime + 64'd10;
   end
   ////////////////////////////////////////////////////////////////////
   task report_and_stop;
      if (failCount == 0 && samplesChecked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   task check(input logic [63:0] seen, input logic [63:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         failCount++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Read bytes land on the taking edge, checked at the falling edge after it
   always @(negedge clk)
   begin
      if (netSeen === 1'b1)
         check(netRdata, netQ.pop_front());
      if (hostSeen === 1'b1)
         check(hostRdata, hostQ.pop_front());
   end
   task automatic xfer(input bit h, input bit w, input logic [11:0] a,
                       input logic [63:0] v, input int n);
      for (int i = 0; i < n; i++)
      begin
         if (!w && h)
            hostQ.push_back(v[8*i +: 8]);
         if (!w && !h)
            netQ.push_back(v[8*i +: 8]);
         if (h)
            hostM.access(w, a + 12'(i), v[8*i +: 8]);
         else
            netM.access(w, a + 12'(i), v[8*i +: 8]);
      end
   endtask : xfer
   task automatic waitFor(ref logic s, output logic [63:0] t);
      for (int i = 0; i < 3000 && s !== 1'b1; i++)
         @(negedge clk);
      t = sysTime;
   endtask : waitFor
   task frame;
      @(posedge clk);
      frameEnd <= 1'b1;
      @(posedge clk);
      frameEnd <= 1'b0;
   endtask : frame
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      xfer(0, 0, ADDR_WIDTH_LO, 64'h0, 3);
      xfer(0, 0, ADDR_FIRST_STATE, 64'h0, 2);
      // At most eight bytes per call, the value is only 64 bits wide
      xfer(1, 0, ADDR_NEXT_SECOND, 64'h0, 8);
      xfer(1, 0, ADDR_PERIOD, 64'h0, 8);
      xfer(0, 0, 12'h9b0, 64'h0, 1);
      cfgWidth <= 16'h0003;
      cfgWidthValid <= 1'b1;
      @(posedge clk);
      cfgWidthValid <= 1'b0;
      xfer(0, 1, ADDR_WIDTH_LO, 64'h55, 1);
      xfer(1, 0, ADDR_WIDTH_LO, 64'h0003, 2);
      r = {$random(seed), $random(seed)};
      xfer(1, 1, ADDR_PERIOD, r, 1);
      xfer(0, 0, ADDR_PERIOD, 64'h0, 1);
      xfer(0, 1, ADDR_CTRL, 64'h1, 1);
      xfer(1, 1, ADDR_PERIOD, r, 1);
      xfer(0, 1, ADDR_PERIOD, ~r, 1);
      xfer(1, 0, ADDR_PERIOD, r, 1);
      xfer(0, 1, ADDR_CTRL, 64'h0, 1);
      // Long period keeps event clears apart from the next fire
      xfer(0, 1, ADDR_PERIOD, 64'd2000, 4);
      xfer(0, 1, ADDR_DELAY, 64'd30, 4);
      st = sysTime + 64'd1000;
      xfer(0, 1, ADDR_START, st, 8);
      xfer(0, 1, ADDR_ACT, 64'h07, 1);
      xfer(0, 1, ADDR_START, 64'h0, 1);
      xfer(1, 0, ADDR_ACT_STATE, 64'h03, 1);
      xfer(1, 0, ADDR_START, st, 8);
      waitFor(firstPulseOut, t1);
      repeat (2) @(negedge clk);
      check(firstPulseOut, 1'b1);
      @(negedge clk);
      check(firstPulseOut, 1'b0);
      waitFor(secondPulseOut, t2);
      check(t2 - t1, 64'd30);
      xfer(1, 0, ADDR_ACT_STATE, 64'h00, 1);
      check({appEventFirst, appEventSecond}, 2'b11);
      xfer(1, 1, ADDR_FIRST_STATE, 64'h0, 1);
      @(negedge clk);
      check(appEventFirst, 1'b1);
      xfer(1, 0, ADDR_FIRST_STATE, 64'h0, 1);
      @(negedge clk);
      check(appEventFirst, 1'b0);
      xfer(1, 0, ADDR_SECOND_STATE, 64'h0, 1);
      @(negedge clk);
      check(appEventSecond, 1'b0);
      waitFor(firstPulseOut, t3);
      check(t3 - t1, 64'd2000);
      @(posedge clk);
      hostWriteAck <= 1'b1;
      waitFor(secondPulseOut, t2);
      check(t2 - t3, 64'd30);
      xfer(1, 1, ADDR_FIRST_STATE, 64'h0, 1);
      xfer(1, 1, ADDR_SECOND_STATE, 64'h0, 1);
      @(negedge clk);
      check({appEventFirst, appEventSecond}, 2'b00);
      xfer(0, 1, ADDR_ACT, 64'h0, 1);
      cfgWidth <= 16'h0000;
      cfgWidthValid <= 1'b1;
      @(posedge clk);
      cfgWidthValid <= 1'b0;
      xfer(0, 1, ADDR_PERIOD, 64'h0, 4);
      xfer(0, 1, ADDR_START, sysTime + 64'd500, 8);
      xfer(0, 1, ADDR_ACT, 64'h03, 1);
      waitFor(firstPulseOut, t1);
      repeat (20) @(negedge clk);
      check(firstPulseOut, 1'b1);
      xfer(0, 0, ADDR_FIRST_STATE, 64'h0, 1);
      repeat (2) @(negedge clk);
      check(firstPulseOut, 1'b0);
      waitFor(firstPulseOut, t3);
      check(firstPulseOut, 1'b0);
      xfer(0, 1, ADDR_ACT, 64'h0, 1);
      xfer(0, 1, ADDR_START, sysTime - 64'h1_0000_0000, 8);
      xfer(0, 1, ADDR_ACT, 64'h63, 1);
      xfer(0, 0, ADDR_ACT_STATE, 64'h04, 1);
      @(negedge clk);
      check(firstPulseOut, 1'b1);
      // Flush stale start flags before auto is on, else the frame activates
      frame;
      xfer(0, 1, ADDR_ACT, 64'h0a, 1);
      st = sysTime + 64'd3000;
      xfer(0, 1, ADDR_START, st, 4);
      frame;
      xfer(0, 0, ADDR_ACT, 64'h0b, 1);
      xfer(0, 0, ADDR_START + 12'h4, st >> 32, 4);
      // Network read acks the held pulse; first pulse still pending
      xfer(0, 0, ADDR_FIRST_STATE, 64'h1, 1);
      @(negedge clk);
      check(firstPulseOut, 1'b0);
      xfer(0, 1, ADDR_ACT, 64'h8b, 1);
      @(negedge clk);
      check(firstPulseOut, 1'b1);
      repeat (3) @(posedge clk);
      report_and_stop;
   end
   initial
   begin
      #300000;
      failCount++;
      report_and_stop;
   end
endmodule : testbench
